// ===== hw/spcs_pkg.sv
// Constants for the sector-protection command decoder.
// Assumes raw active-low write and read strobes; the decoder resolves the write strobe into a single-clock strobe itself.
// Contract
// - Mode entry is AA@555, 55@2AA, then code 40/60/C0/50/E0 at 555.
// - Any mode exits on writes 90 then 00 at any address.
// - Lock program is A0 then data at lock address; read returns register.
// - Lock bits: 0 secured sector, 1 persistent, 2 password, 3 OTP mode.
// - Program clearing both mode bits aborts, device returns to persistent mode; code drops to MODE_NONE with the lock register kept.
// - Password reads at word addresses 0 to 3 return one word each.
// - Password is 64 bits in four 16-bit words chosen by A1:A0.
// - Erase all persistent bits is 80 then 30 at address 00.
// - Erase pre-programs all persistent bits before clearing them.
// - Status read gives DQ0 zero when protected, one when unprotected.
// - Wrong or misordered cycles leave undefined state; reset command restores. Code honours F0 only while modeReg is MODE_NONE and ignores it inside a mode.
// - Address and data bits outside the command fields are ignored.
// - Sector address is address bits 23 down to 14.
// - Bank address is address bits 23 down to 20.
// - Freeze mode: A0 then 00 sets freeze; bank read returns it on DQ0.
// - Data is taken on the first rising edge of write or chip enable.
package spcs_pkg;
	localparam int          ADDR_W       = 24;
	localparam int          DATA_W       = 16;
	localparam int          SECT_HI      = 23;
	localparam int          SECT_LO      = 14;
	localparam int          SECT_N       = 1024;
	localparam int          BANK_LO      = 20;
	localparam logic [11:0] ADR_UNLOCK1  = 12'h555;
	localparam logic [11:0] ADR_UNLOCK2  = 12'h2aa;
	localparam logic [7:0]  ADR_LOCKREG  = 8'h77;
	localparam logic [7:0]  CMD_AA       = 8'haa;
	localparam logic [7:0]  CMD_55       = 8'h55;
	localparam logic [7:0]  CMD_LOCKMODE = 8'h40;
	localparam logic [7:0]  CMD_PWMODE   = 8'h60;
	localparam logic [7:0]  CMD_NVMODE   = 8'hc0;
	localparam logic [7:0]  CMD_FRZMODE  = 8'h50;
	localparam logic [7:0]  CMD_VOLMODE  = 8'he0;
	localparam logic [7:0]  CMD_EXIT1    = 8'h90;
	localparam logic [7:0]  CMD_EXIT2    = 8'h00;
	localparam logic [7:0]  CMD_PROG     = 8'ha0;
	localparam logic [7:0]  CMD_ERASE1   = 8'h80;
	localparam logic [7:0]  CMD_ERASE2   = 8'h30;
	localparam logic [7:0]  CMD_ULK1     = 8'h25;
	localparam logic [7:0]  CMD_ULK2     = 8'h03;
	localparam logic [7:0]  CMD_ULK3     = 8'h29;
	localparam logic [7:0]  CMD_RESET    = 8'hf0;
	localparam logic [7:0]  DAT_SET      = 8'h00;
	localparam logic [7:0]  DAT_CLR      = 8'h01;
	localparam int          LB_SECURED   = 0;
	localparam int          LB_PERSIST   = 1;
	localparam int          LB_PASSWORD  = 2;
	localparam int          LB_OTP       = 3;
	localparam logic [15:0] LOCK_RESET   = 16'hffff;
	localparam logic [63:0] PW_RESET     = 64'hffffffffffffffff;
	typedef enum logic [7:0] {
		ST_IDLE  = 8'h01,
		ST_UNL1  = 8'h02,
		ST_UNL2  = 8'h04,
		ST_MODE  = 8'h08,
		ST_PROG  = 8'h10,
		ST_EXIT  = 8'h20,
		ST_ERASE = 8'h40,
		ST_ULK   = 8'h80
	} spcs_step_type;
	typedef enum logic [5:0] {
		MODE_NONE = 6'h01,
		MODE_LOCK = 6'h02,
		MODE_PW   = 6'h04,
		MODE_NV   = 6'h08,
		MODE_FRZ  = 6'h10,
		MODE_VOL  = 6'h20
	} spcs_mode_type;
endpackage : spcs_pkg

// ===== hw/spcs_decoder.sv
// Sector-protection command decoder: modes, lock register, password, sector bits.
// Assumes raw active-low strobes from pins; address and data sampled twice before use.
`timescale 1ns/1ps
module spcs_decoder (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        weN,
	input  wire logic        ceN,
	input  wire logic        oeN,
	input  wire logic [23:0] addr,
	input  wire logic [15:0] dataIn,
	input  wire logic        largest,
	output logic      [15:0] dataOut,
	output logic             dataOe,
	output logic      [5:0]  modeOut,
	output logic             pwUnlocked,
	output logic             busy
);
	logic [2:0]  weSync;
	logic [2:0]  ceSync;
	logic [1:0]  oeSync;
	logic [23:0] addrS1;
	logic [23:0] addrS2;
	logic [15:0] dataS1;
	logic [15:0] dataS2;
	logic        wrStrobe;
	logic        rdActive;
	spcs_pkg::spcs_mode_type modeReg;
	spcs_pkg::spcs_step_type stepReg;
	logic [2:0]  ulkCnt;
	logic        ulkOk;
	logic [15:0] lockReg;
	logic [63:0] pwReg;
	logic        frozenReg;
	logic        unlockedReg;
	localparam int SECT_N_L = spcs_pkg::SECT_N;
	logic [SECT_N_L-1:0] nvBits;
	logic [SECT_N_L-1:0] volBits;
	logic [1:0]  eraseStep;
	logic [9:0]  sect;
	logic [7:0]  dLo;
	logic [11:0] aLo;
	logic [15:0] lockMerged;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			weSync <= 3'h7;
			ceSync <= 3'h7;
			oeSync <= 2'h3;
			addrS1 <= 24'h000000;
			addrS2 <= 24'h000000;
			dataS1 <= 16'h0000;
			dataS2 <= 16'h0000;
		end else begin
			weSync <= {weSync[1:0], weN};
			ceSync <= {ceSync[1:0], ceN};
			oeSync <= {oeSync[0], oeN};
			addrS1 <= addr;
			addrS2 <= addrS1;
			dataS1 <= dataIn;
			dataS2 <= dataS1;
		end
	end

	// Write ends on the first rising strobe while the other is still low
	assign wrStrobe = (weSync[1] & ~weSync[2] & ~ceSync[2]) |
			(ceSync[1] & ~ceSync[2] & ~weSync[2]);
	assign rdActive = ~oeSync[1] & ~ceSync[2] & weSync[2];
	assign dLo  = dataS2[7:0];
	assign aLo  = addrS2[11:0];
	assign sect = addrS2[spcs_pkg::SECT_HI:spcs_pkg::SECT_LO];
	// Lock bits only go to zero, so the conflict is judged on the merged value
	assign lockMerged = lockReg & dataS2;

	function automatic logic isLockAdr(input logic [7:0] a, input logic big);
		isLockAdr = big ? (a == spcs_pkg::ADR_LOCKREG) : (a == 8'h00);
	endfunction : isLockAdr

	function automatic logic [15:0] pwWord(input logic [63:0] p, input logic [1:0] s);
		pwWord = p[{s, 4'h0} +: 16];
	endfunction : pwWord

	// Command sequencer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			modeReg     <= spcs_pkg::MODE_NONE;
			stepReg     <= spcs_pkg::ST_IDLE;
			ulkCnt      <= 3'h0;
			ulkOk       <= 1'b1;
			lockReg     <= spcs_pkg::LOCK_RESET;
			pwReg       <= spcs_pkg::PW_RESET;
			frozenReg   <= 1'b0;
			unlockedReg <= 1'b0;
			nvBits      <= '1;
			volBits     <= '1;
			eraseStep   <= 2'h0;
		end else begin
			// Erase pre-programs then clears in two cycles
			if (eraseStep == 2'h1) begin
				nvBits    <= '0;
				eraseStep <= 2'h2;
			end else if (eraseStep == 2'h2) begin
				nvBits    <= '1;
				eraseStep <= 2'h0;
			end
			if (wrStrobe && eraseStep == 2'h0) begin
				if (dLo == spcs_pkg::CMD_RESET && modeReg == spcs_pkg::MODE_NONE) begin
					stepReg <= spcs_pkg::ST_IDLE;
				end else if (modeReg == spcs_pkg::MODE_NONE) begin
					unique case (stepReg)
						spcs_pkg::ST_UNL1: begin
							stepReg <= (aLo == spcs_pkg::ADR_UNLOCK2 && dLo == spcs_pkg::CMD_55)
								? spcs_pkg::ST_UNL2 : spcs_pkg::ST_IDLE;
						end
						spcs_pkg::ST_UNL2: begin
							stepReg <= spcs_pkg::ST_MODE;
							if (aLo == spcs_pkg::ADR_UNLOCK1) begin
								unique case (dLo)
									spcs_pkg::CMD_LOCKMODE: modeReg <= spcs_pkg::MODE_LOCK;
									spcs_pkg::CMD_PWMODE:   modeReg <= spcs_pkg::MODE_PW;
									spcs_pkg::CMD_NVMODE:   modeReg <= spcs_pkg::MODE_NV;
									spcs_pkg::CMD_FRZMODE:  modeReg <= spcs_pkg::MODE_FRZ;
									spcs_pkg::CMD_VOLMODE:  modeReg <= spcs_pkg::MODE_VOL;
									default:                stepReg <= spcs_pkg::ST_IDLE;
								endcase
							end else begin
								stepReg <= spcs_pkg::ST_IDLE;
							end
						end
						default: begin
							stepReg <= (aLo == spcs_pkg::ADR_UNLOCK1 && dLo == spcs_pkg::CMD_AA)
								? spcs_pkg::ST_UNL1 : spcs_pkg::ST_IDLE;
						end
					endcase
				end else begin
					unique case (stepReg)
						spcs_pkg::ST_EXIT: begin
							if (dLo == spcs_pkg::CMD_EXIT2) begin
								modeReg <= spcs_pkg::MODE_NONE;
							end
							stepReg <= (dLo == spcs_pkg::CMD_EXIT2) ? spcs_pkg::ST_IDLE
								: spcs_pkg::ST_MODE;
						end
						spcs_pkg::ST_PROG: begin
							stepReg <= spcs_pkg::ST_MODE;
							unique case (modeReg)
								spcs_pkg::MODE_LOCK: begin
									if (isLockAdr(addrS2[7:0], largest)) begin
										if (!lockMerged[spcs_pkg::LB_PERSIST] &&
											!lockMerged[spcs_pkg::LB_PASSWORD]) begin
											modeReg <= spcs_pkg::MODE_NONE;
											stepReg <= spcs_pkg::ST_IDLE;
										end else begin
											lockReg <= lockMerged;
										end
									end
								end
								spcs_pkg::MODE_PW: begin
									pwReg[{addrS2[1:0], 4'h0} +: 16] <= dataS2;
								end
								spcs_pkg::MODE_NV: begin
									if (dLo == spcs_pkg::DAT_SET && !frozenReg) begin
										nvBits[sect] <= 1'b0;
									end
								end
								spcs_pkg::MODE_FRZ: begin
									if (dLo == spcs_pkg::DAT_SET) begin
										frozenReg <= 1'b1;
									end
								end
								default: begin
									if (dLo == spcs_pkg::DAT_SET) begin
										volBits[sect] <= 1'b0;
									end else if (dLo == spcs_pkg::DAT_CLR) begin
										volBits[sect] <= 1'b1;
									end
								end
							endcase
						end
						spcs_pkg::ST_ERASE: begin
							stepReg <= spcs_pkg::ST_MODE;
							if (aLo[7:0] == 8'h00 && dLo == spcs_pkg::CMD_ERASE2 && !frozenReg) begin
								eraseStep <= 2'h1;
							end
						end
						spcs_pkg::ST_ULK: begin
							// Words 0..3 at count 2..5, final 29 at count 6
							if (ulkCnt == 3'h1) begin
								ulkOk <= ulkOk & (dLo == spcs_pkg::CMD_ULK2);
							end else if (ulkCnt < 3'h6) begin
								ulkOk <= ulkOk & (dataS2 == pwWord(pwReg, addrS2[1:0]))
									& (addrS2[1:0] == 2'(ulkCnt - 3'h2));
							end else begin
								unlockedReg <= ulkOk & (dLo == spcs_pkg::CMD_ULK3);
								stepReg     <= spcs_pkg::ST_MODE;
							end
							ulkCnt <= ulkCnt + 3'h1;
						end
						default: begin
							if (dLo == spcs_pkg::CMD_EXIT1) begin
								stepReg <= spcs_pkg::ST_EXIT;
							end else if (dLo == spcs_pkg::CMD_PROG) begin
								stepReg <= spcs_pkg::ST_PROG;
							end else if (dLo == spcs_pkg::CMD_ERASE1 &&
								modeReg == spcs_pkg::MODE_NV) begin
								stepReg <= spcs_pkg::ST_ERASE;
							end else if (dLo == spcs_pkg::CMD_ULK1 &&
								modeReg == spcs_pkg::MODE_PW) begin
								stepReg <= spcs_pkg::ST_ULK;
								ulkCnt  <= 3'h1;
								ulkOk   <= 1'b1;
							end
						end
					endcase
				end
			end
		end
	end

	// Read data path
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dataOut <= 16'h0000;
			dataOe  <= 1'b0;
		end else begin
			dataOe <= rdActive && modeReg != spcs_pkg::MODE_NONE;
			unique case (modeReg)
				spcs_pkg::MODE_LOCK: dataOut <= lockReg;
				spcs_pkg::MODE_PW:   dataOut <= pwWord(pwReg, addrS2[1:0]);
				spcs_pkg::MODE_NV:   dataOut <= {15'h0000, nvBits[sect]};
				spcs_pkg::MODE_FRZ:  dataOut <= {15'h0000, ~frozenReg};
				spcs_pkg::MODE_VOL:  dataOut <= {15'h0000, volBits[sect]};
				default:             dataOut <= 16'h0000;
			endcase
		end
	end

	assign modeOut    = modeReg;
	assign pwUnlocked = unlockedReg;
	assign busy       = eraseStep != 2'h0;

	property p_erase_done;
		@(posedge clk) disable iff (rst)
		(eraseStep == 2'h1) |=> (nvBits == '0) ##1 (nvBits == '1);
	endproperty
	a_erase_done: assert property (p_erase_done) else $error("erase sequence wrong");

	property p_exit_mode;
		@(posedge clk) disable iff (rst)
		(wrStrobe && stepReg == spcs_pkg::ST_EXIT && dLo == 8'h00 && eraseStep == 2'h0
			&& modeReg != spcs_pkg::MODE_NONE) |=> (modeReg == spcs_pkg::MODE_NONE);
	endproperty
	a_exit_mode: assert property (p_exit_mode) else $error("exit not taken");

	property p_mode_onehot;
		@(posedge clk) disable iff (rst)
		$onehot(modeReg);
	endproperty
	a_mode_onehot: assert property (p_mode_onehot) else $error("mode not one-hot");

	property p_lock_bits_keep;
		@(posedge clk) disable iff (rst)
		!(lockReg[spcs_pkg::LB_PERSIST] == 1'b0 && lockReg[spcs_pkg::LB_PASSWORD] == 1'b0);
	endproperty
	a_lock_bits_keep: assert property (p_lock_bits_keep) else $error("both mode bits");

	property p_freeze_sticky;
		@(posedge clk) disable iff (rst)
		frozenReg |=> frozenReg;
	endproperty
	a_freeze_sticky: assert property (p_freeze_sticky) else $error("freeze dropped");

	property p_oe_mode;
		@(posedge clk) disable iff (rst)
		dataOe |-> $past(modeReg) != spcs_pkg::MODE_NONE;
	endproperty
	a_oe_mode: assert property (p_oe_mode) else $error("drive outside mode");

	property p_frozen_nv;
		@(posedge clk) disable iff (rst)
		(frozenReg && eraseStep == 2'h0) |=> !$fell(nvBits[sect]) || eraseStep != 2'h0;
	endproperty
	a_frozen_nv: assert property (p_frozen_nv) else $error("frozen bit changed");

	property p_busy_len;
		@(posedge clk) disable iff (rst)
		$rose(busy) |-> busy [*2] ##1 !busy;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");

	property p_abort_mode;
		@(posedge clk) disable iff (rst)
		(wrStrobe && eraseStep == 2'h0 && stepReg == spcs_pkg::ST_PROG
			&& modeReg == spcs_pkg::MODE_LOCK && isLockAdr(addrS2[7:0], largest)
			&& !lockMerged[spcs_pkg::LB_PERSIST] && !lockMerged[spcs_pkg::LB_PASSWORD])
			|=> (modeReg == spcs_pkg::MODE_NONE) && $stable(lockReg);
	endproperty
	a_abort_mode: assert property (p_abort_mode) else $error("lock conflict kept");

	property p_unlock_rise;
		@(posedge clk) disable iff (rst)
		$rose(pwUnlocked) |-> ($past(stepReg) == spcs_pkg::ST_ULK)
			&& ($past(dLo) == spcs_pkg::CMD_ULK3);
	endproperty
	a_unlock_rise: assert property (p_unlock_rise) else $error("unlock without final");

	property p_read_oe;
		@(posedge clk) disable iff (rst)
		(rdActive && modeReg != spcs_pkg::MODE_NONE) |=> dataOe;
	endproperty
	a_read_oe: assert property (p_read_oe) else $error("read not driven");
endmodule : spcs_decoder

// ===== testbench/spcs_host.sv
// Host bus model: drives write and read cycles on the decoder pins.
// Assumes the decoder synchronises the strobes and samples the bus itself.
`timescale 1ns/1ps
module spcs_host (
	input  wire logic        clk,
	input  wire logic [15:0] dataOut,
	input  wire logic        dataOe,
	output logic             weN,
	output logic             ceN,
	output logic             oeN,
	output logic      [23:0] addr,
	output logic      [15:0] dataIn
);
	initial begin
		weN = 1'b1;
		ceN = 1'b1;
		oeN = 1'b1;
		addr = 24'h000000;
		dataIn = 16'h0000;
	end
	// Write enable rises first, chip enable after; bus inverted once released
	task automatic wr(input logic [23:0] a, input logic [15:0] d);
		@(negedge clk);
		addr = a;
		dataIn = d;
		ceN = 1'b0;
		weN = 1'b0;
		repeat (4) @(negedge clk);
		weN = 1'b1;
		repeat (4) @(negedge clk);
		ceN = 1'b1;
		addr = ~a;
		dataIn = ~d;
		repeat (3) @(negedge clk);
	endtask : wr
	task automatic rd(input logic [23:0] a, output logic [15:0] q);
		@(negedge clk);
		addr = a;
		ceN = 1'b0;
		oeN = 1'b0;
		repeat (6) @(negedge clk);
		q = dataOe ? dataOut : 16'hxxxx;
		oeN = 1'b1;
		ceN = 1'b1;
		addr = ~a;
		repeat (3) @(negedge clk);
	endtask : rd
endmodule : spcs_host

// ===== testbench/spcs_decoder_tb.sv
// Self-checking bench for the sector-protection command decoder.
// Assumes the host model in spcs_host.sv drives all bus pins.
`timescale 1ns/1ps
module spcs_decoder_tb;
	logic        clk;
	logic        rst;
	logic        largest;
	logic        weN, ceN, oeN, dataOe, pwUnlocked, busy;
	logic [23:0] addr;
	logic [23:0] la;
	logic [15:0] dataIn, dataOut, q, v;
	logic [15:0] pw [4];
	logic [5:0]  modeOut;
	logic [9:0]  s;
	logic [7:0]  codes [5] = '{8'h40, 8'h60, 8'hc0, 8'h50, 8'he0};
	int          fail_count = 0;
	int          checked = 0;
	int          busyCnt = 0;

	spcs_decoder DUT (.clk, .rst, .weN, .ceN, .oeN, .addr, .dataIn, .largest,
		.dataOut, .dataOe, .modeOut, .pwUnlocked, .busy);
	spcs_host HOST (.clk, .dataOut, .dataOe, .weN, .ceN, .oeN, .addr, .dataIn);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Busy cycles, counted on the falling clock edge
	always @(negedge clk) begin
		if (busy) busyCnt++;
	end

	function automatic logic [5:0] modeOf(input logic [7:0] c);
		case (c)
			8'h40: return spcs_pkg::MODE_LOCK;
			8'h60: return spcs_pkg::MODE_PW;
			8'hc0: return spcs_pkg::MODE_NV;
			8'h50: return spcs_pkg::MODE_FRZ;
			default: return spcs_pkg::MODE_VOL;
		endcase
	endfunction : modeOf
	function automatic logic [23:0] sect(input logic [9:0] n);
		return {n, 14'($urandom)};
	endfunction : sect

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	task automatic cmd(input logic [11:0] a, input logic [15:0] d);
		HOST.wr({12'($urandom), a}, d);
	endtask : cmd
	task automatic op(input logic [11:0] a, input logic [7:0] c);
		cmd(a, {8'($urandom), c});
	endtask : op
	task automatic enter(input logic [7:0] c);
		op(12'h555, 8'haa);
		op(12'h2aa, 8'h55);
		op(12'h555, c);
	endtask : enter
	task automatic leave;
		op(12'($urandom), 8'h90);
		op(12'($urandom), 8'h00);
	endtask : leave
	task automatic st(input logic [23:0] a, input logic e);
		HOST.rd(a, q);
		chk({15'h0, q[0]}, {15'h0, e});
	endtask : st
	task automatic prog(input logic [23:0] a, input logic [7:0] c);
		op(12'($urandom), 8'ha0);
		HOST.wr(a, {8'($urandom), c});
	endtask : prog
	task automatic unlock(input logic bad);
		op(12'h000, 8'h25);
		op(12'h000, 8'h03);
		for (int k = 0; k < 4; k++)
			cmd(12'(k), pw[k] ^ 16'(bad && k == 2));
		op(12'h000, 8'h29);
	endtask : unlock

	initial begin
		#100000;
		fail_count++;
		end_sim();
	end

	initial begin
		rst = 1'b1;
		void'($urandom(32'h2587e7b1));
		largest = 1'($urandom);
		la = largest ? 24'h000077 : 24'h000000;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		chk(16'(modeOut), 16'(spcs_pkg::MODE_NONE));
		chk(16'({dataOe, pwUnlocked, busy}), 16'h0000);
		foreach (codes[i]) begin
			enter(codes[i]);
			chk(16'(modeOut), 16'(modeOf(codes[i])));
			leave();
			chk(16'(modeOut), 16'(spcs_pkg::MODE_NONE));
		end
		op(12'h555, 8'haa);
		op(12'h2aa, 8'h55);
		op(12'($urandom), 8'hf0);
		op(12'h555, 8'h40);
		chk(16'(modeOut), 16'(spcs_pkg::MODE_NONE));
		enter(8'h60);
		for (int k = 0; k < 4; k++) begin
			pw[k] = 16'($urandom);
			op(12'($urandom), 8'ha0);
			cmd(12'(k), pw[k]);
		end
		for (int k = 0; k < 4; k++) begin
			HOST.rd(24'(k), q);
			chk(q, pw[k]);
		end
		unlock(1'b1);
		chk(16'(pwUnlocked), 16'h0000);
		unlock(1'b0);
		chk(16'(pwUnlocked), 16'h0001);
		leave();
		s = 10'($urandom);
		enter(8'hc0);
		prog(sect(s), 8'h00);
		st(sect(s), 1'b0);
		st(sect(s + 10'h1), 1'b1);
		op(12'($urandom), 8'h80);
		op(12'h000, 8'h30);
		st(sect(s), 1'b1);
		chk(16'(busyCnt), 16'h0002);
		leave();
		enter(8'he0);
		prog(sect(s), 8'h00);
		st(sect(s), 1'b0);
		prog(sect(s), 8'h01);
		st(sect(s), 1'b1);
		leave();
		enter(8'h50);
		st(sect(s), 1'b1);
		prog(sect(s), 8'h00);
		st(sect(s), 1'b0);
		leave();
		enter(8'hc0);
		prog(sect(s), 8'h00);
		st(sect(s), 1'b1);
		leave();
		enter(8'h40);
		HOST.rd(la, q);
		chk(q, spcs_pkg::LOCK_RESET);
		v = {12'($urandom), 4'hd};
		op(12'($urandom), 8'ha0);
		cmd(la[11:0], v);
		HOST.rd(la, q);
		chk(q, v & spcs_pkg::LOCK_RESET);
		op(12'($urandom), 8'ha0);
		cmd(la[11:0], 16'hfffb);
		chk(16'(modeOut), 16'(spcs_pkg::MODE_NONE));
		enter(8'h40);
		HOST.rd(la, q);
		chk(q, v);
		leave();
		end_sim();
	end
endmodule : spcs_decoder_tb
